//--- rtl/sflc_top.sv
// function latch and feedback latch control of the frequency synthesizer
`timescale 1ns/10ps
`default_nettype none
module sflc_top
	import sflc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          serial_clk,
	input  wire logic          serial_data,
	input  wire logic          latch_strobe,
	input  wire logic          chip_enable,
	input  wire logic          ref_in,
	input  wire logic          fb_in,
	input  wire logic          lock_detect_in,
	output sflc_pkg::sflc_pump_t pump,
	output logic               multiplexed_output_pin,
	output logic               lock_detect_reset,
	output logic               rf_debias,
	output logic               ref_buffer_off,
	output logic               counters_held,
	output logic               fastlock_active
);
	import sflc_pkg::*;

	localparam int unsigned NPIN = 6;

	// pin synchronisers: three stages, change accepted when stages two and three agree
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_clean;

	assign pin_raw = {serial_clk, serial_data, latch_strobe, chip_enable, ref_in, fb_in};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic f_q;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					f_q  <= 1'b0;
				end
				else
				begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						f_q <= s3_q;
				end
			end
			assign pin_clean[gi] = f_q;
		end
	endgenerate

	logic sclk_c;
	logic sdata_c;
	logic strobe_c;
	logic ce_c;
	logic ref_c;
	logic fb_c;

	assign {sclk_c, sdata_c, strobe_c, ce_c, ref_c, fb_c} = pin_clean;

	// serial word capture
	logic [WORD_W-1:0] word;
	logic              word_load;

	sflc_serial_in u_serial (
		.clk    (clk),
		.rst_n  (rst_n),
		.sclk   (sclk_c),
		.sdata  (sdata_c),
		.strobe (strobe_c),
		.word   (word),
		.load   (word_load)
	);

	logic ld_ref;
	logic ld_fb;
	logic ld_fn;
	logic ld_init;

	assign ld_ref  = word_load && (word_sel(word) == SEL_REF);
	assign ld_fb   = word_load && (word_sel(word) == SEL_FB);
	assign ld_fn   = word_load && (word_sel(word) == SEL_FN);
	assign ld_init = word_load && (word_sel(word) == SEL_INIT);

	// function settings, shared by function and initialization loads
	sflc_fn_t fn_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fn_q <= sflc_fn_t'(FN_RESET);
		else if (ld_fn || ld_init)
			fn_q <= sflc_fn_t'(word[FN_PD2:FN_CNT_RST]);
	end

	// reference divide value
	logic [RDIV_W-1:0] rdiv_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdiv_q <= RDIV_RESET;
		else if (ld_ref)
			rdiv_q <= word[RW_DIV_MSB:RW_DIV_LSB];
	end

	// feedback divide value; bits 23..22 and 7..2 are never looked at
	logic [NDIV_W-1:0] ndiv_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ndiv_q <= NDIV_RESET;
		else if (ld_fb)
			ndiv_q <= word[NW_DIV_MSB:NW_DIV_LSB];
	end

	// extra reset pulse: on init load, and again on the first feedback load after it
	logic init_armed_q;
	logic init_pulse_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			init_armed_q <= 1'b0;
			init_pulse_q <= 1'b0;
		end
		else
		begin
			init_pulse_q <= ld_init || (ld_fb && init_armed_q);
			if (ld_init)
				init_armed_q <= 1'b1;
			else if (ld_fb)
				init_armed_q <= 1'b0;
		end
	end

	// programmed power-down sequencing
	sflc_pd_state_t pd_state_q;
	logic           cp_event;
	logic           pd_prog;
	logic           pd_active;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pd_state_q <= PD_RUN;
		else
		begin
			case (pd_state_q)
				PD_RUN:
				begin
					if (fn_q.pd1 && fn_q.pd2)
						pd_state_q <= PD_WAIT;
				end
				PD_WAIT:
				begin
					if (!(fn_q.pd1 && fn_q.pd2))
						pd_state_q <= PD_RUN;
					else if (cp_event)
						pd_state_q <= PD_DOWN;
				end
				PD_DOWN:
				begin
					if (!fn_q.pd1)
						pd_state_q <= PD_RUN;
				end
				default:
				begin
					pd_state_q <= PD_RUN;
				end
			endcase
		end
	end

	// asynchronous mode needs no state: the latched bits act directly
	assign pd_prog   = (fn_q.pd1 && !fn_q.pd2) || (pd_state_q == PD_DOWN);
	assign pd_active = !ce_c || (ce_c && pd_prog);

	// counters are held at load state by counter reset, init pulse or power-down
	logic hold;

	assign hold = fn_q.cnt_rst || init_pulse_q || pd_active;

	// reference and feedback counters count filtered input edges
	logic              ref_prev_q;
	logic              fb_prev_q;
	logic [RDIV_W-1:0] rcnt_q;
	logic [NDIV_W-1:0] ncnt_q;
	logic              ref_pulse_q;
	logic              fb_pulse_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_prev_q <= 1'b0;
			fb_prev_q  <= 1'b0;
		end
		else
		begin
			ref_prev_q <= ref_c;
			fb_prev_q  <= fb_c;
		end
	end

	// both counters share one hold, so release restarts them in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rcnt_q      <= RDIV_RESET;
			ref_pulse_q <= 1'b0;
		end
		else
		begin
			ref_pulse_q <= 1'b0;
			if (hold)
				rcnt_q <= rdiv_q;
			else if (ref_c && !ref_prev_q)
			begin
				if (rcnt_q <= RDIV_W'(1))
				begin
					rcnt_q      <= rdiv_q;
					ref_pulse_q <= 1'b1;
				end
				else
					rcnt_q <= rcnt_q - RDIV_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ncnt_q     <= NDIV_RESET;
			fb_pulse_q <= 1'b0;
		end
		else
		begin
			fb_pulse_q <= 1'b0;
			if (hold)
				ncnt_q <= ndiv_q;
			else if (fb_c && !fb_prev_q)
			begin
				if (ncnt_q <= NDIV_W'(1))
				begin
					ncnt_q     <= ndiv_q;
					fb_pulse_q <= 1'b1;
				end
				else
					ncnt_q <= ncnt_q - NDIV_W'(1);
			end
		end
	end

	assign cp_event = ref_pulse_q || fb_pulse_q;

	// phase detector: reference edge raises up, feedback edge raises down
	logic up_q;
	logic dn_q;
	logic up_n;
	logic dn_n;

	assign up_n = up_q || ref_pulse_q;
	assign dn_n = dn_q || fb_pulse_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end
		else if (hold || (up_n && dn_n))
		begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
		end
		else
		begin
			up_q <= up_n;
			dn_q <= dn_n;
		end
	end

	// fastlock gain flag; a host write in the same cycle as expiry wins
	logic gain_q;
	logic to_expire;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			gain_q <= 1'b0;
		else if (ld_fb)
			gain_q <= word[NW_GAIN];
		else if (to_expire)
			gain_q <= 1'b0;
	end

	sflc_fl_timer u_timer (
		.clk    (clk),
		.rst_n  (rst_n),
		.hold   (pd_active),
		.run    (fn_q.fl_en && fn_q.fl_mode && gain_q),
		.start  (ld_fb && word[NW_GAIN]),
		.tick   (ref_pulse_q),
		.tc     (fn_q.tc),
		.expire (to_expire)
	);

	logic fast;

	assign fast = fn_q.fl_en && gain_q;

	// pump outputs; the polarity bit swaps drive, power-down forces high impedance
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pump            <= '0;
			pump.hiz        <= 1'b1;
			fastlock_active <= 1'b0;
		end
		else
		begin
			pump.up         <= fn_q.pol ? up_q : dn_q;
			pump.dn         <= fn_q.pol ? dn_q : up_q;
			pump.hiz        <= fn_q.tri_st || hold;
			pump.cur        <= fast ? fn_q.cur2 : fn_q.cur1;
			fastlock_active <= fast;
		end
	end

	// power-down side effects, registered so they start from reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_detect_reset <= 1'b1;
			rf_debias         <= 1'b1;
			ref_buffer_off    <= 1'b1;
			counters_held     <= 1'b1;
		end
		else
		begin
			lock_detect_reset <= pd_active;
			rf_debias         <= pd_active;
			ref_buffer_off    <= pd_active;
			counters_held     <= hold;
		end
	end

	// output multiplexer
	logic mux_n;

	always_comb
	begin
		case (fn_q.outsel)
			3'h0:    mux_n = 1'b0;
			3'h1:    mux_n = lock_detect_in;
			3'h2:    mux_n = fb_pulse_q;
			3'h3:    mux_n = 1'b1;
			3'h4:    mux_n = ref_pulse_q;
			3'h5:    mux_n = fast;
			3'h6:    mux_n = sdata_c;
			default: mux_n = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			multiplexed_output_pin <= 1'b0;
		else
			multiplexed_output_pin <= mux_n;
	end
endmodule
`default_nettype wire

//--- rtl/sflc_pkg.sv
// shared constants and types for the synthesizer latch control
package sflc_pkg;

	localparam int unsigned WORD_W       = 24;
	localparam int unsigned SYNC_STAGES  = 3;
	localparam int unsigned SEL_W        = 2;

	localparam logic [1:0]  SEL_REF      = 2'h0;
	localparam logic [1:0]  SEL_FB       = 2'h1;
	localparam logic [1:0]  SEL_FN       = 2'h2;
	localparam logic [1:0]  SEL_INIT     = 2'h3;

	localparam int unsigned FN_CNT_RST   = 2;
	localparam int unsigned FN_PD2       = 21;

	localparam int unsigned NW_GAIN      = 21;
	localparam int unsigned NW_DIV_LSB   = 8;
	localparam int unsigned NW_DIV_MSB   = 20;
	localparam int unsigned NDIV_W       = 13;

	localparam int unsigned RW_DIV_LSB   = 2;
	localparam int unsigned RW_DIV_MSB   = 15;
	localparam int unsigned RDIV_W       = 14;

	localparam logic [19:0] FN_RESET     = 20'h00001;
	localparam logic [12:0] NDIV_RESET   = 13'h0001;
	localparam logic [13:0] RDIV_RESET   = 14'h0001;

	localparam logic [7:0]  TO_BASE      = 8'h03;
	localparam logic [7:0]  TO_STEP      = 8'h04;

	typedef enum logic [1:0] {
		PD_RUN  = 2'b00,
		PD_WAIT = 2'b01,
		PD_DOWN = 2'b11
	} sflc_pd_state_t;

	typedef struct packed {
		logic       pd2;
		logic [2:0] cur2;
		logic [2:0] cur1;
		logic [3:0] tc;
		logic       fl_mode;
		logic       fl_en;
		logic       tri_st;
		logic       pol;
		logic [2:0] outsel;
		logic       pd1;
		logic       cnt_rst;
	} sflc_fn_t;

	typedef struct packed {
		logic       up;
		logic       dn;
		logic       hiz;
		logic [2:0] cur;
	} sflc_pump_t;

	function automatic logic [1:0] word_sel(input logic [WORD_W-1:0] w);
		word_sel = w[SEL_W-1:0];
	endfunction

endpackage

//--- rtl/sflc_serial_in.sv
// serial input shift register with strobe transfer
`timescale 1ns/10ps
`default_nettype none
module sflc_serial_in
	import sflc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              sclk,
	input  wire logic              sdata,
	input  wire logic              strobe,
	output logic [WORD_W-1:0]      word,
	output logic                   load
);
	logic [WORD_W-1:0] shift_q;
	logic              sclk_prev_q;
	logic              strobe_prev_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_prev_q   <= 1'b0;
			strobe_prev_q <= 1'b0;
		end
		else
		begin
			sclk_prev_q   <= sclk;
			strobe_prev_q <= strobe;
		end
	end

	// msb first, one bit per rising serial clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= '0;
		else if (sclk && !sclk_prev_q)
			shift_q <= {shift_q[WORD_W-2:0], sdata};
	end

	// never gated by power-down, so words are still taken while disabled
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word <= '0;
			load <= 1'b0;
		end
		else
		begin
			load <= strobe && !strobe_prev_q;
			if (strobe && !strobe_prev_q)
				word <= shift_q;
		end
	end
endmodule
`default_nettype wire

//--- rtl/sflc_fl_timer.sv
// fastlock timeout counter, counted in phase detector cycles
`timescale 1ns/10ps
`default_nettype none
module sflc_fl_timer
	import sflc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       hold,
	input  wire logic       run,
	input  wire logic       start,
	input  wire logic       tick,
	input  wire logic [3:0] tc,
	output logic            expire
);
	logic [7:0] cnt_q;
	logic       busy_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			expire <= 1'b0;
		end
		else
		begin
			expire <= 1'b0;
			if (hold)
			begin
				cnt_q  <= '0;
				busy_q <= 1'b0;
			end
			else if (start)
			begin
				cnt_q  <= 8'(TO_BASE + TO_STEP * {4'h0, tc});
				busy_q <= 1'b1;
			end
			else if (busy_q && run && tick)
			begin
				if (cnt_q <= 8'h01)
				begin
					busy_q <= 1'b0;
					expire <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/sflc_asserts.sv
// port checks for the synthesizer latch control
`timescale 1ns/10ps
`default_nettype none
module sflc_asserts
	import sflc_pkg::*;
(
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	latch_strobe,
	input wire logic	chip_enable,
	input wire sflc_pump_t	pump,
	input wire logic	lock_detect_reset,
	input wire logic	rf_debias,
	input wire logic	ref_buffer_off,
	input wire logic	counters_held,
	input wire logic	fastlock_active
);
	logic [5:0]	stb_age_q;
	logic [3:0]	ce_age_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ages saturate so an old strobe never looks recent again
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stb_age_q <= 6'h3F;
		else if (latch_strobe)
			stb_age_q <= 6'h00;
		else if (stb_age_q != 6'h3F)
			stb_age_q <= stb_age_q + 6'h01;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ce_age_q <= 4'h0;
		else if (!chip_enable)
			ce_age_q <= 4'h0;
		else if (ce_age_q != 4'hF)
			ce_age_q <= ce_age_q + 4'h1;
	end
	a_ce_low_down: assert property (!chip_enable [*8] |-> ##2 rf_debias && counters_held)
		else $error("chip enable low left device up");
	a_down_effects: assert property (rf_debias |-> lock_detect_reset && ref_buffer_off)
		else $error("power-down side outputs differ");
	a_down_pump: assert property (rf_debias [*2] |-> pump.hiz && counters_held)
		else $error("pump driven during power-down");
	a_held_quiet: assert property (counters_held [*2] |-> pump.hiz && !pump.up && !pump.dn)
		else $error("pump active while counters held");
	a_fl_cause: assert property ($rose(fastlock_active) |-> stb_age_q < 6'h14)
		else $error("fastlock entered without a load");
	a_ce_resume: assert property ($fell(rf_debias) |-> ce_age_q != 4'h0)
		else $error("power-down left with chip enable low");
	a_hiz_release: assert property ($fell(pump.hiz) |-> ##[0:2] !rf_debias)
		else $error("pump enabled while powered down");
	a_reset_state: assert property (disable iff (1'h0) !rst_n |-> counters_held && !fastlock_active)
		else $error("wrong state in reset");
	cover property ($rose(fastlock_active));
	cover property ($fell(rf_debias));
	cover property ($fell(counters_held));
endmodule
bind sflc_top sflc_asserts sflc_asserts_inst (
	.clk(clk), .rst_n(rst_n), .latch_strobe(latch_strobe), .chip_enable(chip_enable),
	.pump(pump), .lock_detect_reset(lock_detect_reset), .rf_debias(rf_debias),
	.ref_buffer_off(ref_buffer_off), .counters_held(counters_held),
	.fastlock_active(fastlock_active)
);
`default_nettype wire

//--- dv/sflc_host_model.sv
// host that shifts words into the three-wire port
`timescale 1ns/10ps
`default_nettype none
module sflc_host_model
(
	input wire logic	clk,
	output var logic	sclk,
	output var logic	sdata,
	output var logic	stb
);
	initial
	begin
		sclk = 1'h0;
		sdata = 1'h0;
		stb = 1'h0;
	end
	task automatic hold4();
		repeat (4) @(posedge clk);
		#1;
	endtask
	// serial clock parked low between words, 80 ns period inside a word
	task automatic send(input logic [23:0] w);
		int i;
		for (i = 23; i >= 0; i--)
		begin
			sdata = w[i];
			hold4();
			sclk = 1'h1;
			hold4();
			sclk = 1'h0;
		end
		// released data line flips so a stale bit never looks valid
		sdata = ~sdata;
		hold4();
		stb = 1'h1;
		hold4();
		stb = 1'h0;
	endtask
endmodule
`default_nettype wire

//--- dv/sflc_top_tb_top.sv
// self-checking bench for the synthesizer latch control
`timescale 1ns/10ps
`default_nettype none
module sflc_top_tb_top;
	import sflc_pkg::*;
	localparam int LIMIT = 20000;
	logic		clk = 1'h0;
	logic		rst_n = 1'h1;
	logic		ce = 1'h1;
	logic		ldi = 1'h1;
	logic		ref_in = 1'h0;
	logic		fb_in = 1'h0;
	logic		ref_run = 1'h1;
	logic		fb_run = 1'h1;
	logic		sclk;
	logic		sdata;
	logic		stb;
	sflc_pump_t	pump;
	logic		mux;
	logic		ldr;
	logic		deb;
	logic		rbo;
	logic		held;
	logic		fla;
	sflc_fn_t	f;
	int		err_total = 0;
	int		n_tests = 0;
	int		cyc = 0;
	logic [2:0]	sl [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h1, 3'h6};
	always #5 clk = ~clk;
	// divider inputs toggle every 5 cycles, slow enough for the pin filter
	always
	begin
		repeat (5) @(posedge clk);
		#1;
		if (ref_run)
			ref_in = ~ref_in;
		if (fb_run)
			fb_in = ~fb_in;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_total++;
			give_verdict();
		end
	end
	sflc_host_model sflc_host_model_inst (.clk(clk), .sclk(sclk), .sdata(sdata), .stb(stb));
	sflc_top sflc_top_inst (
		.clk(clk), .rst_n(rst_n), .serial_clk(sclk), .serial_data(sdata),
		.latch_strobe(stb), .chip_enable(ce), .ref_in(ref_in), .fb_in(fb_in),
		.lock_detect_in(ldi), .pump(pump), .multiplexed_output_pin(mux),
		.lock_detect_reset(ldr), .rf_debias(deb), .ref_buffer_off(rbo),
		.counters_held(held), .fastlock_active(fla)
	);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [23:0] w);
		sflc_host_model_inst.send(w);
		repeat (12) @(posedge clk);
		#1;
	endtask
	task automatic wfn(input logic [1:0] s);
		wr({2'h0, f, s});
	endtask
	task automatic wfb(input logic g);
		wr({2'h0, g, 13'h0001, 6'h2A, SEL_FB});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		int k;
		// a real falling edge, so the asynchronous resets fire at the start
		#1;
		rst_n = 1'h0;
		repeat (16) @(posedge clk);
		#1;
		check("reset", 8'({held, pump.hiz, fla, mux, deb}), 8'h19);
		rst_n = 1'h1;
		repeat (5) @(posedge clk);
		#1;
		f = '0;
		// select 6 shows the data line, left flipped to one after a function word
		for (k = 0; k < 6; k++)
		begin
			ldi = (k != 4);
			f.outsel = sl[k];
			wfn(SEL_FN);
			check("mux", 8'(mux),
				8'(sl[k] == 3'h3 || sl[k] == 3'h6 || (sl[k] == 3'h1 && ldi)));
		end
		check("run", 8'(held), 8'h00);
		f.cnt_rst = 1'h1;
		wfn(SEL_FN);
		check("held", 8'({held, pump.hiz, pump.up, pump.dn}), 8'h0C);
		f.cnt_rst = 1'h0;
		wfn(SEL_FN);
		check("released", 8'(held), 8'h00);
		$display("test select done");
		f.outsel = 3'h3;
		wfn(SEL_INIT);
		check("init mux", 8'(mux), 8'h01);
		wr(24'h000004);
		wfb(1'h0);
		check("mux kept", 8'(mux), 8'h01);
		$display("test init done");
		f.fl_en = 1'h1;
		f.cur1 = 3'h2;
		f.cur2 = 3'h5;
		f.outsel = 3'h5;
		wfn(SEL_FN);
		wfb(1'h1);
		check("fl1 on", 8'({fla, mux, pump.cur}), 8'h1D);
		repeat (200) @(posedge clk);
		#1;
		check("fl1 kept", 8'(fla), 8'h01);
		wfb(1'h0);
		check("fl1 off", 8'({fla, mux, pump.cur}), 8'h02);
		f.fl_mode = 1'h1;
		f.tc = 4'h1;
		wfn(SEL_FN);
		wfb(1'h1);
		repeat (40) @(posedge clk);
		#1;
		check("fl2 on", 8'({fla, pump.cur}), 8'h0D);
		repeat ((TO_BASE + TO_STEP) * 10) @(posedge clk);
		#1;
		check("fl2 off", 8'({fla, pump.cur}), 8'h02);
		f.fl_en = 1'h0;
		wfn(SEL_FN);
		wfb(1'h1);
		check("fl disabled", 8'({fla, pump.cur}), 8'h02);
		$display("test fastlock done");
		fb_run = 1'h0;
		f.pol = 1'h1;
		wfn(SEL_FN);
		check("pol up", 8'({pump.hiz, pump.up, pump.dn}), 8'h02);
		f.pol = 1'h0;
		wfn(SEL_FN);
		check("pol dn", 8'({pump.hiz, pump.up, pump.dn}), 8'h01);
		f.tri_st = 1'h1;
		wfn(SEL_FN);
		check("tri", 8'(pump.hiz), 8'h01);
		f.tri_st = 1'h0;
		$display("test pump done");
		ce = 1'h0;
		f.outsel = 3'h3;
		wfn(SEL_FN);
		check("ce down", 8'({deb, ldr, rbo, held, pump.hiz, mux}), 8'h3F);
		ce = 1'h1;
		repeat (10) @(posedge clk);
		#1;
		check("ce up", 8'(deb), 8'h00);
		f.pd1 = 1'h1;
		wfn(SEL_FN);
		check("async pd", 8'({deb, held}), 8'h03);
		f.pd1 = 1'h0;
		wfn(SEL_FN);
		ref_run = 1'h0;
		f.pd1 = 1'h1;
		f.pd2 = 1'h1;
		wfn(SEL_FN);
		check("sync wait", 8'(deb), 8'h00);
		ref_run = 1'h1;
		repeat (30) @(posedge clk);
		#1;
		check("sync pd", 8'(deb), 8'h01);
		$display("test power-down done");
		give_verdict();
	end
endmodule
`default_nettype wire
